// [rtl/mdu_pkg.sv]
// Package with register addresses, field positions and timing for the unit.
package mdu_pkg;
	localparam logic [7:0] ADDR_OP0  = 8'h00_E9;
	localparam logic [7:0] ADDR_OP1  = 8'h00_EA;
	localparam logic [7:0] ADDR_OP2  = 8'h00_EB;
	localparam logic [7:0] ADDR_OP3  = 8'h00_EC;
	localparam logic [7:0] ADDR_OP4  = 8'h00_ED;
	localparam logic [7:0] ADDR_OP5  = 8'h00_EE;
	localparam logic [7:0] ADDR_CTRL = 8'h00_EF;
	localparam int BIT_ERR = 7;
	localparam int BIT_OVF = 6;
	localparam int BIT_DIR = 5;
	localparam logic [7:0] CTRL_RESET = 8'h00_00;
	localparam logic [5:0] DIR_CNT_MASK = 6'h00_3F;
	localparam logic [4:0] CYC_DIV32 = 5'h00_11;
	localparam logic [4:0] CYC_DIV16 = 5'h00_09;
	localparam logic [4:0] CYC_MUL   = 5'h00_0B;
	localparam logic [4:0] CYC_SHIFT_BASE = 5'h00_02;
	localparam logic [4:0] CYC_NORM_BASE  = 5'h00_03;
	localparam logic [31:0] MUL_LIMIT = 32'h0000_FFFF;
	typedef enum logic [4:0] {
		OP_NONE  = 5'b00001,
		OP_DIV32 = 5'b00010,
		OP_DIV16 = 5'b00100,
		OP_MUL   = 5'b01000,
		OP_SHIFT = 5'b10000
	} op_e;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN  = 3'b010,
		ST_DONE = 3'b100
	} state_e;
endpackage

// [rtl/multiply_divide_unit.sv]
// Unsigned multiply, divide, shift and normalize co-processor.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module multiply_divide_unit (
	input  wire logic       i_clk_sys,
	input  wire logic       i_srst,
	input  wire logic [7:0] i_sfr_addr,
	input  wire logic       i_sfr_wr,
	input  wire logic       i_sfr_rd,
	input  wire logic [7:0] i_sfr_wdata,
	output logic      [7:0] o_sfr_rdata,
	output logic            o_busy
);
	// Operand bytes, flags and sequencer state.
	logic [7:0]          md_reg [6];
	logic                err_reg;
	logic                ovf_reg;
	logic [5:0]          dir_cnt_reg;
	mdu_pkg::op_e        op_reg;
	mdu_pkg::state_e     state_reg;
	logic [4:0]          cyc_reg;
	logic                armed_reg;
	logic [7:0]          rdata_reg;
	logic [31:0]         res_lo;
	logic [15:0]         res_hi;
	logic [4:0]          norm_cnt;
	logic                res_ovf;
	logic [4:0]          run_len;
	logic [31:0]         word_a;
	logic [15:0]         divisor;
	logic                wr_md;
	logic                wr_ctrl;
	logic                rd_md;
	logic                rd_ctrl;
	logic                launch;
	logic                running;
	logic                last_rd;
	logic                done;
	logic                is_div;
	logic                norm_sel;
	logic [4:0]          half_cnt;

	assign word_a  = {md_reg[3], md_reg[2], md_reg[1], md_reg[0]};
	assign divisor = {md_reg[5], md_reg[4]};
	assign wr_md   = i_sfr_wr && i_sfr_addr >= mdu_pkg::ADDR_OP0
		&& i_sfr_addr <= mdu_pkg::ADDR_OP5;
	assign wr_ctrl = i_sfr_wr && i_sfr_addr == mdu_pkg::ADDR_CTRL;
	assign rd_md   = i_sfr_rd && i_sfr_addr >= mdu_pkg::ADDR_OP0
		&& i_sfr_addr <= mdu_pkg::ADDR_OP5;
	assign rd_ctrl = i_sfr_rd && i_sfr_addr == mdu_pkg::ADDR_CTRL;
	assign running = state_reg == mdu_pkg::ST_RUN;
	assign o_busy  = running;
	// Launch decodes the write order collected since byte 0 was written.
	// A lone byte 5 write after reset selects nothing and so starts
	// nothing, which keeps a stray store from running a stale operation.
	assign launch = (i_sfr_wr && i_sfr_addr == mdu_pkg::ADDR_OP5
		&& op_reg != mdu_pkg::OP_NONE) || wr_ctrl;
	assign is_div   = op_reg == mdu_pkg::OP_DIV32
		|| op_reg == mdu_pkg::OP_DIV16;
	assign norm_sel = dir_cnt_reg[4:0] == 5'h00_00;
	assign done     = running && cyc_reg >= run_len;
	// A read that ends the calculation only counts once the run is over;
	// reading early is an error case and must keep the checking armed.
	assign last_rd = i_sfr_rd && state_reg == mdu_pkg::ST_DONE
		&& ((is_div && i_sfr_addr == mdu_pkg::ADDR_OP5)
		|| (!is_div && i_sfr_addr == mdu_pkg::ADDR_OP3));
	// Shift time grows by one cycle for every two positions, rounded up.
	assign half_cnt = 5'(({1'b0, dir_cnt_reg[4:0]} + 6'h01) >> 1);

	////////////////////////////////////////////////////////////////////////
	// The whole result is formed combinationally and committed when the
	// cycle count expires; this trades area for a simple exact latency.
	// Normalize counts its shifts here too, so its length is known early.
	always_comb begin
		logic [31:0] tmp;
		logic [31:0] prod;
		tmp      = word_a;
		prod     = 32'h0000_0000;
		res_lo   = word_a;
		res_hi   = divisor;
		norm_cnt = 5'h00_00;
		res_ovf  = 1'b0;
		run_len  = mdu_pkg::CYC_MUL;
		unique case (op_reg)
			// Division by zero leaves the operands as loaded and only
			// raises overflow, so software can still see its inputs.
			mdu_pkg::OP_DIV32: begin
				run_len = mdu_pkg::CYC_DIV32;
				res_ovf = divisor == 16'h0000;
				if (!res_ovf) begin
					res_lo = word_a / {16'h0000, divisor};
					res_hi = 16'(word_a % {16'h0000, divisor});
				end
			end
			mdu_pkg::OP_DIV16: begin
				run_len = mdu_pkg::CYC_DIV16;
				res_ovf = divisor == 16'h0000;
				if (!res_ovf) begin
					res_lo = {md_reg[3], md_reg[2],
						word_a[15:0] / divisor};
					res_hi = word_a[15:0] % divisor;
				end
			end
			mdu_pkg::OP_MUL: begin
				prod    = word_a[15:0] * divisor;
				res_lo  = prod;
				res_ovf = prod > mdu_pkg::MUL_LIMIT;
			end
			mdu_pkg::OP_SHIFT: begin
				if (norm_sel) begin
					res_ovf = word_a[31];
					// A zero word shifts the full 31 places and stays zero.
					// The loop is unrolled, so its depth costs area only.
					for (int i = 0; i < 31; i++) begin
						if (!tmp[31]) begin
							tmp      = {tmp[30:0], 1'b0};
							norm_cnt = 5'(norm_cnt + 5'h00_01);
						end
					end
					res_lo  = tmp;
					run_len = 5'(5'((6'(norm_cnt) + 6'h01) >> 1)
						+ mdu_pkg::CYC_NORM_BASE);
				end else begin
					res_lo = dir_cnt_reg[mdu_pkg::BIT_DIR]
						? word_a >> dir_cnt_reg[4:0]
						: word_a << dir_cnt_reg[4:0];
					run_len = 5'(half_cnt
						+ mdu_pkg::CYC_SHIFT_BASE);
				end
			end
			default: begin
				run_len = mdu_pkg::CYC_MUL;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Operation selection from write order. Bytes 1 and 4 each pick their
	// own operation and the later of the two wins, so a multiply loaded
	// as 0, 4, 1, 5 and a short divide loaded as 0, 1, 4, 5 both decode.
	// Bytes 2 or 3 hold the long divide until byte 0 opens a new load or a control write selects shift.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			op_reg <= mdu_pkg::OP_NONE;
		end else if (i_sfr_wr) begin
			unique case (i_sfr_addr)
				mdu_pkg::ADDR_OP0: op_reg <= mdu_pkg::OP_NONE;
				mdu_pkg::ADDR_OP2,
				mdu_pkg::ADDR_OP3: op_reg <= mdu_pkg::OP_DIV32;
				mdu_pkg::ADDR_OP4: begin
					if (op_reg != mdu_pkg::OP_DIV32) begin
						op_reg <= mdu_pkg::OP_DIV16;
					end
				end
				mdu_pkg::ADDR_OP1: begin
					if (op_reg != mdu_pkg::OP_DIV32) begin
						op_reg <= mdu_pkg::OP_MUL;
					end
				end
				mdu_pkg::ADDR_CTRL: op_reg <= mdu_pkg::OP_SHIFT;
				default: op_reg <= op_reg;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer; a control or byte 5 write during a run restarts from the new order.
	// A control or byte 5 write relaunches with the new count at once, while any
	// other operand write drops to idle: the old operands are already partly
	// replaced, so only a fresh load can give a meaningful result.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			state_reg <= mdu_pkg::ST_IDLE;
			cyc_reg   <= 5'h00_00;
		end else if (launch) begin
			state_reg <= mdu_pkg::ST_RUN;
			cyc_reg   <= 5'h00_01;
		end else if (wr_md && running) begin
			state_reg <= mdu_pkg::ST_IDLE;
			cyc_reg   <= 5'h00_00;
		end else if (running) begin
			if (cyc_reg >= run_len) begin
				state_reg <= mdu_pkg::ST_DONE;
			end
			cyc_reg <= 5'(cyc_reg + 5'h00_01);
		end else if (last_rd) begin
			state_reg <= mdu_pkg::ST_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Operand bytes take processor writes, then the results.
	// A processor write wins over a result commit in the same cycle.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			for (int i = 0; i < 6; i++) begin
				md_reg[i] <= 8'h00_00;
			end
		end else if (wr_md) begin
			md_reg[3'(i_sfr_addr - mdu_pkg::ADDR_OP0)] <= i_sfr_wdata;
		end else if (done) begin
			{md_reg[3], md_reg[2], md_reg[1], md_reg[0]} <= res_lo;
			if (is_div) begin
				{md_reg[5], md_reg[4]} <= res_hi;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Direction and count. The flag bits are not stored here, so a write
	// can never reach them.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			dir_cnt_reg <= mdu_pkg::CTRL_RESET[5:0];
		end else if (wr_ctrl) begin
			dir_cnt_reg <= i_sfr_wdata[5:0] & mdu_pkg::DIR_CNT_MASK;
		end else if (done && op_reg == mdu_pkg::OP_SHIFT && norm_sel) begin
			dir_cnt_reg[4:0] <= norm_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Overflow follows the outcome of the last finished operation only.
	// A run aborted before its last cycle leaves it alone, since no result was produced.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			ovf_reg <= mdu_pkg::CTRL_RESET[mdu_pkg::BIT_OVF];
		end else if (done) begin
			ovf_reg <= res_ovf;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checking is armed from the first byte 0 write to the final read.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			armed_reg <= 1'b0;
		end else if (i_sfr_wr && i_sfr_addr == mdu_pkg::ADDR_OP0) begin
			armed_reg <= 1'b1;
		end else if (last_rd) begin
			armed_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Setting wins over the read clear so no error is lost.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			err_reg <= 1'b0;
		end else if (running && ((wr_md || wr_ctrl)
			|| (rd_md && armed_reg))) begin
			err_reg <= 1'b1;
		end else if (rd_ctrl) begin
			err_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data is registered and holds until the next read strobe;
	// unmapped addresses answer zero.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			rdata_reg <= 8'h00_00;
		end else if (rd_md) begin
			rdata_reg <= md_reg[3'(i_sfr_addr - mdu_pkg::ADDR_OP0)];
		end else if (rd_ctrl) begin
			rdata_reg <= {err_reg, ovf_reg, dir_cnt_reg};
		end else if (i_sfr_rd) begin
			rdata_reg <= 8'h00_00;
		end
	end
	assign o_sfr_rdata = rdata_reg;
endmodule

// [verif/mdu_checker.sv]
// Port checker for the multiply divide unit.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
module mdu_checker (
	input  wire logic       i_clk_sys,
	input  wire logic       i_srst,
	input  wire logic [7:0] i_sfr_addr,
	input  wire logic       i_sfr_wr,
	input  wire logic       i_sfr_rd,
	input  wire logic [7:0] i_sfr_wdata,
	input  wire logic [7:0] o_sfr_rdata,
	input  wire logic       o_busy
);
	logic [5:0] run_reg;
	logic       op_wr;
	logic       mapped;
	assign mapped = i_sfr_addr inside {[mdu_pkg::ADDR_OP0:mdu_pkg::ADDR_CTRL]};
	assign op_wr = i_sfr_wr && mapped && (i_sfr_addr != mdu_pkg::ADDR_CTRL);
	// Busy cycles so far; a relaunch keeps counting, so the bound fits only the longest single run of 19 busy cycles.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst || !o_busy) begin
			run_reg <= 6'h00;
		end else begin
			run_reg <= run_reg + 6'h01;
		end
	end
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	a_unmapped_zero: assert property (i_sfr_rd && !mapped |=>
		o_sfr_rdata == 8'h00) else $error("unmapped read not zero");
	a_launch_cause: assert property ($rose(o_busy) |->
		$past(i_sfr_wr)) else $error("busy rose without a write");
	a_busy_limit: assert property (o_busy |->
		run_reg < 6'h13) else $error("calculation ran too long");
	a_busy_min: assert property (($rose(o_busy) && !op_wr) ##1
		!op_wr |-> o_busy ##1 o_busy) else $error("calculation too short");
	a_reset_idle: assert property (disable iff (1'b0) i_srst |=>
		!o_busy && o_sfr_rdata == 8'h00) else $error("reset not idle");
	a_rdata_hold: assert property (!$past(i_sfr_rd) |->
		$stable(o_sfr_rdata)) else $error("read data moved");
	a_ctrl_relaunch: assert property (i_sfr_wr && o_busy &&
		i_sfr_addr == mdu_pkg::ADDR_CTRL && i_sfr_wdata[4:0] == 5'h01 |=>
		o_busy [*3] ##1 !o_busy) else $error("relaunch length wrong");
	a_op_abort: assert property (op_wr && o_busy
		&& i_sfr_addr != mdu_pkg::ADDR_OP5 |=>
		!o_busy) else $error("operand write did not abort");
endmodule
bind multiply_divide_unit mdu_checker chk_i (.i_clk_sys(i_clk_sys),
	.i_srst(i_srst), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
	.i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
	.o_sfr_rdata(o_sfr_rdata), .o_busy(o_busy));

// [verif/cpu_model.sv]
// Processor model that loads, launches and reads back the unit.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
module cpu_model (
	input  wire logic       i_clk_sys,
	input  wire logic [7:0] i_rdata,
	output logic      [7:0] o_addr,
	output logic            o_wr,
	output logic            o_rd,
	output logic      [7:0] o_wdata
);
	initial begin
		o_addr = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = 8'h00;
	end
	// Data is inverted after the strobe so a stale byte is never reused.
	task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk_sys);
		o_addr = a;
		o_wdata = d;
		o_wr = 1'b1;
		@(negedge i_clk_sys);
		o_wr = 1'b0;
		o_wdata = ~d;
	endtask
	task automatic rd_b(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_clk_sys);
		o_addr = a;
		o_rd = 1'b1;
		@(negedge i_clk_sys);
		o_rd = 1'b0;
		d = i_rdata;
	endtask
	// Kind 0 multiply, 1 short divide, 2 long divide, 3 shift or normalize.
	task automatic load(input logic [1:0] k, input logic [31:0] a,
		input logic [15:0] b, input logic [7:0] c);
		wr_b(mdu_pkg::ADDR_OP0, a[7:0]);
		if (k == 2'h0) wr_b(mdu_pkg::ADDR_OP4, b[7:0]);
		wr_b(mdu_pkg::ADDR_OP1, a[15:8]);
		if (k[1]) wr_b(mdu_pkg::ADDR_OP2, a[23:16]);
		if (k[1]) wr_b(mdu_pkg::ADDR_OP3, a[31:24]);
		if (k == 2'h1 || k == 2'h2) wr_b(mdu_pkg::ADDR_OP4, b[7:0]);
		if (k == 2'h3) wr_b(mdu_pkg::ADDR_CTRL, c);
		else wr_b(mdu_pkg::ADDR_OP5, b[15:8]);
	endtask
endmodule

// [verif/multiply_divide_unit_bench.sv]
// Self-checking bench for the multiply divide unit.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
module multiply_divide_unit_bench;
	typedef struct packed {
		logic [1:0]  k;
		logic [31:0] a;
		logic [15:0] b;
		logic [7:0]  c;
		logic [47:0] r;
		logic [5:0]  m;
		logic [7:0]  x;
		logic [4:0]  n;
	} row_s;
	// Arithmetic rows come first so the count field is still zero there.
	row_s rows [10] = '{
		'{2'h0, 32'h1234, 16'h5678, 8'h0, 48'h0626_0060, 6'h0F, 8'h40, 5'd11},
		'{2'h0, 32'h0010, 16'h0020, 8'h0, 48'h0200, 6'h0F, 8'h00, 5'd11},
		'{2'h1, 32'h1234, 16'h0010, 8'h0, 48'h0004_0000_0123, 6'h33, 8'h0, 5'd9},
		'{2'h2, 32'h1234_5678, 16'h0100, 8'h0, 48'h0078_0012_3456, 6'h3F, 8'h0,
			5'd17},
		'{2'h1, 32'h1234, 16'h0000, 8'h0, 48'h1234, 6'h33, 8'h40, 5'd0},
		'{2'h3, 32'h8000_0001, 16'h0, 8'h01, 48'h0002, 6'h0F, 8'h01, 5'd3},
		'{2'h3, 32'h8000_0001, 16'h0, 8'h3F, 48'h0001, 6'h0F, 8'h3F, 5'd18},
		'{2'h3, 32'h4000_0000, 16'h0, 8'h00, 48'h8000_0000, 6'h0F, 8'h01, 5'd4},
		'{2'h3, 32'h0000_0001, 16'h0, 8'h00, 48'h8000_0000, 6'h0F, 8'h1F, 5'd19},
		'{2'h3, 32'h8000_0000, 16'h0, 8'h00, 48'h8000_0000, 6'h0F, 8'h40, 5'd0}};
	logic        i_clk_sys = 1'b0;
	logic        i_srst = 1'b1;
	logic [7:0]  i_sfr_addr, i_sfr_wdata, o_sfr_rdata, d;
	logic        i_sfr_wr, i_sfr_rd, o_busy;
	logic [47:0] v;
	int          err_count = 0, num_checks = 0, n;
	always #12.5 i_clk_sys = ~i_clk_sys;
	multiply_divide_unit uut (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
		.i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
		.i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .o_busy(o_busy));
	cpu_model cpu (.i_clk_sys(i_clk_sys), .i_rdata(o_sfr_rdata),
		.o_addr(i_sfr_addr), .o_wr(i_sfr_wr), .o_rd(i_sfr_rd),
		.o_wdata(i_sfr_wdata));
	task automatic chk(input string s, input logic [47:0] e, g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic test_done;
		if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic wait_idle;
		n = 0;
		while (o_busy === 1'b1) begin
			n++;
			if (n > 40) begin
				err_count++;
				test_done();
			end
			@(negedge i_clk_sys);
		end
	endtask
	// Last byte read is byte 5 for divisions and byte 3 otherwise.
	task automatic rd_res(input logic [5:0] m);
		v = '0;
		for (int i = 0; i < 6; i++) begin
			if (m[i]) cpu.rd_b(8'(mdu_pkg::ADDR_OP0 + i), v[8*i +: 8]);
		end
	endtask
	task automatic ctl(input logic [7:0] x);
		cpu.rd_b(mdu_pkg::ADDR_CTRL, d);
		chk("control", 48'(x), 48'(d));
	endtask
	initial begin
		repeat (16) @(negedge i_clk_sys);
		i_srst = 1'b0;
		ctl(mdu_pkg::CTRL_RESET);
		foreach (rows[i]) begin
			cpu.load(rows[i].k, rows[i].a, rows[i].b, rows[i].c);
			wait_idle();
			if (rows[i].n != 5'd0) chk("cycles", 48'(rows[i].n), 48'(n));
			rd_res(rows[i].m);
			chk("result", rows[i].r, v);
			ctl(rows[i].x);
		end
		cpu.load(2'h3, 32'h0000_0001, 16'h0, 8'h1F);
		cpu.rd_b(mdu_pkg::ADDR_OP0, d);
		wait_idle();
		rd_res(6'h0F);
		chk("run on", 48'h8000_0000, v);
		ctl(8'h9F);
		ctl(8'h1F);
		cpu.load(2'h3, 32'h0000_0001, 16'h0, 8'h05);
		cpu.wr_b(mdu_pkg::ADDR_CTRL, 8'hC1);
		wait_idle();
		ctl(8'h81);
		cpu.load(2'h0, 32'h1234, 16'h5678, 8'h00);
		cpu.wr_b(mdu_pkg::ADDR_OP0, 8'h00);
		wait_idle();
		cpu.rd_b(mdu_pkg::ADDR_CTRL, d);
		chk("abort", 48'h1, 48'(d[7]));
		i_srst = 1'b1;
		repeat (16) @(negedge i_clk_sys);
		i_srst = 1'b0;
		ctl(mdu_pkg::CTRL_RESET);
		cpu.rd_b(8'h00, d);
		chk("unmapped", 48'h0, 48'(d));
		test_done();
	end
endmodule
